// ### inc/sere_pkg.sv
package sere_pkg;
    // device address word layout
    localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
    localparam int         DEV_TYPE_MSB  = 7;
    localparam int         DEV_TYPE_LSB  = 4;
    localparam int         DEV_SEL_MSB   = 3;
    localparam int         DEV_SEL_LSB   = 1;
    localparam int         RW_BIT        = 0;
    localparam logic       RW_READ       = 1'b1;
    localparam logic       RW_WRITE      = 1'b0;
    // array geometry
    localparam int         ADDR_W        = 12;
    localparam int         ADDR_HI_W     = 4;
    localparam int         BYTE_W        = 8;
    localparam int         MEM_DEPTH     = 4096;
    localparam int         CS_W          = 3;
    // bit counter: 0..7 data bits, 8 is the acknowledge slot
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT      = 4'h8;
    // host timing
    localparam int         CLK_MHZ          = 100;
    localparam int         SCL_KHZ          = 400;
    localparam int         SCL_QTR_CYCLES   = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
    localparam int         POWER_UP_WAIT_US = 100;
    localparam int         POWER_UP_CYCLES  = POWER_UP_WAIT_US * CLK_MHZ;
endpackage

// ### inc/sere_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sere_link_if;
    logic scl_out_h;    // host clock drive value (always low)
    logic scl_oe_h;     // host pulls clock low
    logic sda_out_h;    // host data drive value (always low)
    logic sda_oe_h;     // host pulls data low
    logic sda_out_d;    // device data drive value (always low)
    logic sda_oe_d;     // device pulls data low
    logic scl;          // resolved clock wire
    logic sda;          // resolved data wire

    // open-drain wired-and with pull-ups
    assign scl = scl_oe_h ? scl_out_h : 1'b1;
    assign sda = (sda_oe_h ? sda_out_h : 1'b1) & (sda_oe_d ? sda_out_d : 1'b1);

    modport host (output scl_out_h, output scl_oe_h, output sda_out_h, output sda_oe_h,
                  input scl, input sda);
    modport dev  (output sda_out_d, output sda_oe_d, input scl, input sda);
endinterface
`default_nettype wire

// ### logic/sere_host.sv
`timescale 1ns/1ps
`default_nettype none
module sere_host #(
    parameter int POWER_UP_WAIT_CYCLES = sere_pkg::POWER_UP_CYCLES
) (
    input  wire logic                          clk_in,
    input  wire logic                          rst_in,
    input  wire logic                          cmd_valid_in,
    input  wire logic                          cmd_random_in,
    input  wire logic [sere_pkg::ADDR_W-1:0]   cmd_addr_in,
    input  wire logic [7:0]                    cmd_count_in,
    input  wire logic [sere_pkg::CS_W-1:0]     chip_select_in,
    output logic                               cmd_ready_out,
    output logic [sere_pkg::BYTE_W-1:0]        rd_data_out,
    output logic                               rd_valid_out,
    output logic                               done_out,
    output logic                               nack_out,
    sere_link_if.host                          link
);
    typedef enum logic [2:0] {H_PUP, H_IDLE, H_START, H_BYTE, H_STOP} sere_host_state_t;

    sere_host_state_t                 state;
    logic [31:0]                      pup_cnt;
    logic [15:0]                      qcnt;
    logic                             qtick;
    logic [1:0]                       ph;
    logic [3:0]                       bitn;
    logic [1:0]                       step;     // 0 dev-w, 1 addr hi, 2 addr lo, 3 dev-r
    logic                             rx;
    logic [7:0]                       remain;
    logic [sere_pkg::ADDR_W-1:0]      addr;
    logic [sere_pkg::CS_W-1:0]        cs;
    logic [sere_pkg::BYTE_W-1:0]      rxb;
    logic                             got_nack;
    logic                             sda_m, sda_s;
    logic [sere_pkg::BYTE_W-1:0]      txb;

    // byte sent for each address step
    function automatic logic [7:0] sere_tx_byte(input logic [1:0] s,
                                                input logic [11:0] a, input logic [2:0] c);
        case (s)
            2'd0:    sere_tx_byte = {sere_pkg::DEV_TYPE_CODE, c, sere_pkg::RW_WRITE};
            2'd1:    sere_tx_byte = {4'h0, a[11:8]};
            2'd2:    sere_tx_byte = a[7:0];
            default: sere_tx_byte = {sere_pkg::DEV_TYPE_CODE, c, sere_pkg::RW_READ};
        endcase
    endfunction

    assign txb           = sere_tx_byte(step, addr, cs);
    assign cmd_ready_out = (state == H_IDLE);
    assign link.scl_out_h = 1'b0;
    assign link.sda_out_h = 1'b0;

    // data line synchroniser
    always_ff @(posedge clk_in) begin
        sda_m <= link.sda;
        sda_s <= sda_m;
    end

    // quarter-period tick of the generated clock
    always_ff @(posedge clk_in) begin
        if (rst_in || state == H_IDLE || state == H_PUP || qtick) begin
            qcnt <= 16'h0;
        end else begin
            qcnt <= qcnt + 16'h1;
        end
    end
    assign qtick = (qcnt == 16'(sere_pkg::SCL_QTR_CYCLES - 1));

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pup_cnt <= 32'h0;
        end else if (state == H_PUP) begin
            pup_cnt <= pup_cnt + 32'h1;
        end
    end

    // bit engine
    always_ff @(posedge clk_in) begin
        rd_valid_out <= 1'b0;
        done_out     <= 1'b0;
        if (rst_in) begin
            state         <= H_PUP;
            ph            <= 2'h0;
            bitn          <= 4'h0;
            step          <= 2'h0;
            rx            <= 1'b0;
            remain        <= 8'h0;
            addr          <= '0;
            cs            <= '0;
            rxb           <= '0;
            got_nack      <= 1'b0;
            nack_out      <= 1'b0;
            rd_data_out   <= '0;
            link.scl_oe_h <= 1'b0;
            link.sda_oe_h <= 1'b0;
        end else begin
            case (state)
                H_PUP: begin
                    if (pup_cnt >= 32'(POWER_UP_WAIT_CYCLES - 1)) begin
                        state <= H_IDLE;
                    end
                end
                H_IDLE: begin
                    if (cmd_valid_in) begin
                        addr     <= cmd_addr_in;
                        cs       <= chip_select_in;
                        remain   <= (cmd_count_in == 8'h0) ? 8'h1 : cmd_count_in;
                        // random read opens with a dummy write
                        step     <= cmd_random_in ? 2'd0 : 2'd3;
                        rx       <= 1'b0;
                        nack_out <= 1'b0;
                        ph       <= 2'h0;
                        state    <= H_START;
                    end
                end
                H_START: if (qtick) begin
                    ph <= ph + 2'h1;
                    case (ph)
                        2'h0:    link.sda_oe_h <= 1'b0;
                        2'h1:    link.scl_oe_h <= 1'b0;
                        2'h2:    link.sda_oe_h <= 1'b1;
                        default: begin
                            link.scl_oe_h <= 1'b1;
                            bitn          <= 4'h0;
                            state         <= H_BYTE;
                        end
                    endcase
                end
                H_BYTE: if (qtick) begin
                    ph <= ph + 2'h1;
                    case (ph)
                        2'h0: begin
                            if (bitn == sere_pkg::ACK_SLOT) begin
                                // acknowledge all but the last byte
                                link.sda_oe_h <= rx && (remain != 8'h1);
                            end else begin
                                link.sda_oe_h <= !rx && !txb[3'(sere_pkg::LAST_DATA_BIT - bitn)];
                            end
                        end
                        2'h1: link.scl_oe_h <= 1'b0;
                        2'h2: begin
                            if (bitn == sere_pkg::ACK_SLOT) begin
                                got_nack <= sda_s;
                            end else if (rx) begin
                                rxb <= {rxb[6:0], sda_s};
                            end
                        end
                        default: begin
                            link.scl_oe_h <= 1'b1;
                            bitn          <= bitn + 4'h1;
                            if (bitn == sere_pkg::ACK_SLOT) begin
                                bitn <= 4'h0;
                                if (rx) begin
                                    rd_data_out  <= rxb;
                                    rd_valid_out <= 1'b1;
                                    remain       <= remain - 8'h1;
                                    if (remain == 8'h1) begin
                                        state <= H_STOP;
                                    end
                                end else if (got_nack) begin
                                    nack_out <= 1'b1;
                                    state    <= H_STOP;
                                end else if (step == 2'd3) begin
                                    rx <= 1'b1;
                                end else if (step == 2'd2) begin
                                    step  <= 2'd3;
                                    state <= H_START;
                                end else begin
                                    step <= step + 2'd1;
                                end
                            end
                        end
                    endcase
                end
                H_STOP: if (qtick) begin
                    ph <= ph + 2'h1;
                    case (ph)
                        2'h0:    link.sda_oe_h <= 1'b1;
                        2'h1:    link.scl_oe_h <= 1'b0;
                        2'h2:    link.sda_oe_h <= 1'b0;
                        default: begin
                            done_out <= 1'b1;
                            state    <= H_IDLE;
                        end
                    endcase
                end
                default: state <= H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### logic/sere_dev.sv
`timescale 1ns/1ps
`default_nettype none
module sere_dev (
    input  wire logic                          link_clk_in,
    input  wire logic                          link_rst_in,
    input  wire logic                          por_in,
    input  wire logic [sere_pkg::CS_W-1:0]     chip_select_pins_in,
    input  wire logic                          mem_load_en_in,
    input  wire logic [sere_pkg::ADDR_W-1:0]   mem_load_addr_in,
    input  wire logic [sere_pkg::BYTE_W-1:0]   mem_load_data_in,
    output logic [sere_pkg::ADDR_W-1:0]        addr_counter_out,
    output logic                               read_active_out,
    sere_link_if.dev                           link
);
    typedef enum logic [2:0] {D_IDLE, D_DEV, D_ADDR_HI, D_ADDR_LO, D_WDATA, D_READ}
        sere_dev_state_t;

    sere_dev_state_t                  state;
    logic [5:0]                       sync1, sync2;
    logic                             scl_d, sda_d;
    logic                             scl_s, sda_s, por_s;
    logic [sere_pkg::CS_W-1:0]        cs_s;
    logic                             scl_rise, scl_fall, start_det, stop_det, halt;
    logic [3:0]                       bitcnt;
    logic [sere_pkg::BYTE_W-1:0]      shreg, tx, rx_byte;
    logic                             ack_pend;
    logic [sere_pkg::ADDR_W-1:0]      addr;
    logic [sere_pkg::ADDR_HI_W-1:0]   addr_hi;
    logic                             ninth, load_tx;
    logic [sere_pkg::BYTE_W-1:0]      mem [0:sere_pkg::MEM_DEPTH-1];

    // address word decode against the select pins
    function automatic logic sere_match(input logic [7:0] b, input logic [2:0] c);
        sere_match = (b[sere_pkg::DEV_TYPE_MSB:sere_pkg::DEV_TYPE_LSB] == sere_pkg::DEV_TYPE_CODE)
                  && (b[sere_pkg::DEV_SEL_MSB:sere_pkg::DEV_SEL_LSB] == c);
    endfunction

    // two-stage synchroniser, then one delayed copy for edges
    always_ff @(posedge link_clk_in) begin
        if (link_rst_in) begin
            sync1 <= 6'h03;
            sync2 <= 6'h03;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sync1 <= {por_in, chip_select_pins_in, link.scl, link.sda};
            sync2 <= sync1;
            scl_d <= sync2[1];
            sda_d <= sync2[0];
        end
    end

    assign sda_s    = sync2[0];
    assign scl_s    = sync2[1];
    assign cs_s     = sync2[4:2];
    assign por_s    = sync2[5];
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det  = scl_s && scl_d && !sda_d && sda_s;
    // power-on reset holds the engine idle
    assign halt      = link_rst_in || por_s;
    assign rx_byte   = {shreg[6:0], sda_s};
    assign ninth     = scl_rise && (bitcnt == sere_pkg::ACK_SLOT);
    // fetch on matched read word or controller acknowledge
    assign load_tx   = ninth && (((state == D_DEV) && ack_pend && shreg[sere_pkg::RW_BIT])
                              || ((state == D_READ) && !sda_s));
    assign link.sda_out_d   = 1'b0;
    assign addr_counter_out = addr;

    // backing array, filled from the user side
    always_ff @(posedge link_clk_in) begin
        if (mem_load_en_in) begin
            mem[mem_load_addr_in] <= mem_load_data_in;
        end
    end

    // command state
    always_ff @(posedge link_clk_in) begin
        if (halt) begin
            state <= D_IDLE;
        end else if (start_det) begin
            // new start drops any pending write
            state <= D_DEV;
        end else if (stop_det) begin
            state <= D_IDLE;
        end else if (ninth) begin
            case (state)
                D_DEV: begin
                    if (!ack_pend) begin
                        state <= D_IDLE;
                    end else if (shreg[sere_pkg::RW_BIT] == sere_pkg::RW_READ) begin
                        state <= D_READ;
                    end else begin
                        state <= D_ADDR_HI;
                    end
                end
                D_ADDR_HI: state <= D_ADDR_LO;
                D_ADDR_LO: state <= D_WDATA;
                D_WDATA:   state <= D_WDATA;
                D_READ:    state <= sda_s ? D_IDLE : D_READ;
                default:   state <= D_IDLE;
            endcase
        end
    end

    // bit counter and receive shifter
    always_ff @(posedge link_clk_in) begin
        if (halt || start_det || stop_det) begin
            bitcnt <= 4'h0;
        end else if (scl_rise && state != D_IDLE) begin
            bitcnt <= (bitcnt == sere_pkg::ACK_SLOT) ? 4'h0 : bitcnt + 4'h1;
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (link_rst_in) begin
            shreg <= '0;
        end else if (scl_rise && bitcnt < sere_pkg::ACK_SLOT) begin
            shreg <= rx_byte;
        end
    end

    // acknowledge decision taken on the eighth rising clock
    always_ff @(posedge link_clk_in) begin
        if (halt || start_det || stop_det) begin
            ack_pend <= 1'b0;
        end else if (scl_rise && bitcnt == sere_pkg::LAST_DATA_BIT) begin
            if (state == D_DEV) begin
                ack_pend <= sere_match(rx_byte, cs_s);
            end else begin
                ack_pend <= (state != D_READ) && (state != D_IDLE);
            end
        end
    end

    // word address counter, kept across transactions
    always_ff @(posedge link_clk_in) begin
        if (link_rst_in) begin
            addr_hi <= '0;
            addr    <= '0;
        end else if (!por_s) begin
            if (ninth && state == D_ADDR_HI) begin
                addr_hi <= shreg[sere_pkg::ADDR_HI_W-1:0];
            end
            if (ninth && state == D_ADDR_LO) begin
                addr <= {addr_hi, shreg};
            end else if (scl_rise && bitcnt == sere_pkg::LAST_DATA_BIT && state == D_READ) begin
                // advance after each byte, wraps naturally
                addr <= addr + 12'h1;
            end
        end
    end

    // transmit byte fetch
    always_ff @(posedge link_clk_in) begin
        if (link_rst_in) begin
            tx <= '0;
        end else if (load_tx) begin
            tx <= mem[addr];
        end
    end

    // data line drive, changed after the clock falls, released at once on start, stop, reset or power-on reset
    always_ff @(posedge link_clk_in) begin
        if (halt || start_det || stop_det) begin
            link.sda_oe_d <= 1'b0;
        end else if (scl_fall) begin
            if (state == D_READ && bitcnt < sere_pkg::ACK_SLOT) begin
                link.sda_oe_d <= !tx[3'(sere_pkg::LAST_DATA_BIT - bitcnt)];
            end else if (bitcnt == sere_pkg::ACK_SLOT && ack_pend) begin
                link.sda_oe_d <= 1'b1;
            end else begin
                link.sda_oe_d <= 1'b0;
            end
        end
    end

    // read activity status
    always_ff @(posedge link_clk_in) begin
        if (link_rst_in) begin
            read_active_out <= 1'b0;
        end else begin
            read_active_out <= (state == D_READ);
        end
    end
endmodule
`default_nettype wire

// ### sim/sere_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sere_properties (
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic       link_clk_in,
    input wire logic       link_rst_in,
    input wire logic       por_in,
    input wire logic [2:0] chip_select_pins_in,
    input wire logic       sda_oe_d,
    input wire logic       sda_out_d,
    input wire logic       scl,
    input wire logic       sda
);
    logic       scl_q;
    logic       sda_q;
    logic       rd_mode;
    logic       dev_hit;
    logic [3:0] bit_cnt;
    logic [7:0] byte_cnt;
    logic [7:0] shift_q;
    logic       rise;
    logic       stop_ev;
    logic       start_ev;
    logic       match;
    // wire events seen on the system clock
    assign rise     = scl & ~scl_q;
    assign start_ev = scl & scl_q & sda_q & ~sda;
    assign stop_ev  = scl & scl_q & ~sda_q & sda;
    assign match    = shift_q[7:1] == {4'ha, chip_select_pins_in};
    // previous wire levels
    always_ff @(posedge clk_in) begin
        scl_q <= rst_in | scl;
        sda_q <= rst_in | sda;
    end
    // bit and byte position inside a frame
    always_ff @(posedge clk_in) begin
        if (rst_in || start_ev) begin
            bit_cnt  <= 4'h0;
            byte_cnt <= 8'h00;
        end else if (rise) begin
            bit_cnt  <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
            byte_cnt <= byte_cnt + {7'h00, bit_cnt == 4'h8};
        end
    end
    // received byte, direction and address hit
    always_ff @(posedge clk_in) begin
        if (rise) begin
            shift_q <= {shift_q[6:0], sda};
        end
        if (rise && bit_cnt == 4'h7 && byte_cnt == 8'h00) begin
            rd_mode <= sda;
        end
        if (rise && bit_cnt == 4'h8 && byte_cnt == 8'h00) begin
            dev_hit <= match;
        end
    end
    property p_od_low;
        @(posedge link_clk_in) disable iff (link_rst_in) sda_oe_d |-> !sda_out_d && !sda;
    endproperty
    a_od_low: assert property (p_od_low) else $error("device drives data high");
    property p_dev_edge;
        @(posedge link_clk_in) disable iff (link_rst_in || por_in) $changed(sda_oe_d) |-> !scl;
    endproperty
    a_dev_edge: assert property (p_dev_edge) else $error("data moved with clock high");
    property p_por_quiet;
        @(posedge link_clk_in) disable iff (link_rst_in) por_in [*5] |-> !sda_oe_d;
    endproperty
    a_por_quiet: assert property (p_por_quiet) else $error("bus driven in reset");
    property p_ack_addr;
        @(posedge clk_in) disable iff (rst_in || link_rst_in || por_in)
            rise && bit_cnt == 4'h8 && byte_cnt == 8'h00 && match |-> !sda;
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("address word not acked");
    property p_ack_word;
        @(posedge clk_in) disable iff (rst_in || link_rst_in || por_in)
            rise && bit_cnt == 4'h8 && !rd_mode && dev_hit
            && (byte_cnt == 8'h01 || byte_cnt == 8'h02) |-> !sda;
    endproperty
    a_ack_word: assert property (p_ack_word) else $error("word address not acked");
    property p_nack_other;
        @(posedge clk_in) disable iff (rst_in || link_rst_in || por_in)
            rise && bit_cnt == 4'h8 && byte_cnt == 8'h00 && !match |-> sda;
    endproperty
    a_nack_other: assert property (p_nack_other) else $error("foreign address acked");
    property p_nack_release;
        @(posedge clk_in) disable iff (rst_in || link_rst_in || por_in)
            rise && bit_cnt == 4'h8 && byte_cnt != 8'h00 && rd_mode && sda |-> !sda_oe_d [*8];
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("drive after nack");
    property p_stop_idle;
        @(posedge clk_in) disable iff (rst_in || link_rst_in || por_in)
            stop_ev |-> (scl && !sda_oe_d) [*8];
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("bus busy after stop");
endmodule
`default_nettype wire

// ### sim/serial_eeprom_read_engine_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_engine_tb_top;
    logic        clk_in      = 1'b0;
    logic        link_clk_in = 1'b0;
    logic        rst_in      = 1'b1;
    logic        link_rst_in = 1'b1;
    logic        por_in      = 1'b0;
    logic        cmd_valid   = 1'b0;
    logic        cmd_random  = 1'b0;
    logic [11:0] cmd_addr    = 12'h000;
    logic [7:0]  cmd_count   = 8'h01;
    logic [2:0]  cmd_cs      = 3'h5;
    logic        load_en     = 1'b0;
    logic [11:0] load_addr   = 12'h000;
    logic [7:0]  load_data   = 8'h00;
    logic        cmd_ready;
    logic        rd_valid;
    logic        done;
    logic        nack;
    logic [7:0]  rd_data;
    logic [11:0] addr_cnt;
    logic        rd_act;
    logic        act_seen    = 1'b0;
    logic [7:0]  rx_q[$];
    logic [11:0] pre_addr[7] = '{12'h123, 12'h124, 12'hffe, 12'hfff, 12'h000, 12'h001, 12'h002};
    localparam int PUP_WAIT  = 20;
    int          fail_count  = 0;
    int          num_checks  = 0;
    // system and link clocks, unrelated in phase
    always #5 clk_in = ~clk_in;
    always #24 link_clk_in = ~link_clk_in;
    sere_link_if sere_link_if_inst ();
    sere_host #(.POWER_UP_WAIT_CYCLES(PUP_WAIT)) sere_host_inst (
        .clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid), .cmd_random_in(cmd_random),
        .cmd_addr_in(cmd_addr), .cmd_count_in(cmd_count), .chip_select_in(cmd_cs),
        .cmd_ready_out(cmd_ready), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .done_out(done), .nack_out(nack), .link(sere_link_if_inst));
    sere_dev sere_dev_inst (
        .link_clk_in(link_clk_in), .link_rst_in(link_rst_in), .por_in(por_in),
        .chip_select_pins_in(3'h5), .mem_load_en_in(load_en), .mem_load_addr_in(load_addr),
        .mem_load_data_in(load_data), .addr_counter_out(addr_cnt), .read_active_out(rd_act),
        .link(sere_link_if_inst));
    sere_properties sere_properties_inst (
        .clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
        .link_rst_in(link_rst_in), .por_in(por_in), .chip_select_pins_in(3'h5),
        .sda_oe_d(sere_link_if_inst.sda_oe_d), .sda_out_d(sere_link_if_inst.sda_out_d),
        .scl(sere_link_if_inst.scl), .sda(sere_link_if_inst.sda));
    // array content pattern, distinct for each preloaded address
    function automatic logic [7:0] exp_byte(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h5};
    endfunction
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // backdoor preload of one array byte
    task automatic load_mem(input logic [11:0] a);
        @(posedge link_clk_in);
        load_en   <= 1'b1;
        load_addr <= a;
        load_data <= exp_byte(a);
        @(posedge link_clk_in);
        load_en   <= 1'b0;
    endtask
    // one host command, bytes collected until done
    task automatic run_cmd(input logic rnd, input logic [11:0] a, input logic [7:0] n,
                           input logic [2:0] cs);
        int cnt;
        cnt = 0;
        rx_q.delete();
        while (cmd_ready !== 1'b1 && cnt < 1000) begin
            @(negedge clk_in);
            cnt++;
        end
        @(posedge clk_in);
        cmd_valid  <= 1'b1;
        cmd_random <= rnd;
        cmd_addr   <= a;
        cmd_count  <= n;
        cmd_cs     <= cs;
        @(posedge clk_in);
        cmd_valid  <= 1'b0;
        cnt = 0;
        act_seen = 1'b0;
        do begin
            @(negedge clk_in);
            if (rd_valid === 1'b1) rx_q.push_back(rd_data);
            if (rd_act === 1'b1) act_seen = 1'b1;
            cnt++;
        end while (done !== 1'b1 && cnt < 30000);
        check(12'(cnt < 30000), 12'h001);
        check(12'(rd_act), 12'h000);
    endtask
    // host holds commands off for the power-up wait
    task automatic power_up_wait;
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 1000) begin
            @(negedge clk_in);
            n++;
        end
        check(12'(n), 12'(PUP_WAIT + 1));
    endtask
    task automatic t_random;
        run_cmd(1'b1, 12'h123, 8'h01, 3'h5);
        check(12'(rx_q.size()), 12'h001);
        check(12'(rx_q[0]), 12'(exp_byte(12'h123)));
        check(12'(nack), 12'h000);
        check(addr_cnt, 12'h124);
    endtask
    task automatic t_current;
        run_cmd(1'b0, 12'h000, 8'h01, 3'h5);
        check(12'(rx_q[0]), 12'(exp_byte(12'h124)));
        check(addr_cnt, 12'h125);
        check(12'(act_seen), 12'h001);
    endtask
    task automatic t_wrap;
        logic [11:0] a;
        run_cmd(1'b1, 12'hffe, 8'h04, 3'h5);
        check(12'(rx_q.size()), 12'h004);
        for (int i = 0; i < 4; i++) begin
            a = 12'hffe + 12'(i);
            check(12'(rx_q[i]), 12'(exp_byte(a)));
        end
        check(addr_cnt, 12'h002);
    endtask
    task automatic t_select;
        run_cmd(1'b0, 12'h000, 8'h01, 3'h2);
        check(12'(nack), 12'h001);
        check(12'(rx_q.size()), 12'h000);
        check(addr_cnt, 12'h002);
        check(12'(act_seen), 12'h000);
    endtask
    task automatic t_por;
        @(posedge link_clk_in);
        por_in <= 1'b1;
        repeat (8) @(posedge link_clk_in);
        run_cmd(1'b0, 12'h000, 8'h01, 3'h5);
        check(12'(nack), 12'h001);
        check(12'(rx_q.size()), 12'h000);
        @(posedge link_clk_in);
        por_in <= 1'b0;
        repeat (8) @(posedge link_clk_in);
        run_cmd(1'b0, 12'h000, 8'h01, 3'h5);
        check(12'(rx_q[0]), 12'(exp_byte(12'h002)));
        check(addr_cnt, 12'h003);
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        power_up_wait();
        repeat (3) @(posedge link_clk_in);
        link_rst_in <= 1'b0;
        foreach (pre_addr[i]) load_mem(pre_addr[i]);
        t_random();
        t_current();
        t_wrap();
        t_select();
        t_por();
        finish_test();
    end
    // watchdog against a hung transfer
    initial begin
        repeat (90000) @(posedge clk_in);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end
endmodule
`default_nettype wire
